/* inc/dha_pkg.sv */
// Package: constants, types and register map of the distance and hours accumulator
`default_nettype none
package dha_pkg;

	// ========================================
	// Timing
	localparam int unsigned CLK_MHZ        = 250;
	localparam int unsigned TICK_MS        = 100;
	localparam int unsigned TICK_CYC_DEF   = TICK_MS * CLK_MHZ * 1000;
	localparam int unsigned HALF_SEC_MS    = 500;
	localparam int unsigned PERIOD_10S_MS  = 10000;
	localparam int unsigned SPEED_LOSS_MS  = 8000;
	localparam int unsigned TENTH_HOUR_MS  = 360000;
	localparam logic [7:0]  HALF_SEC_TICKS = 8'(HALF_SEC_MS / TICK_MS);
	localparam logic [7:0]  TEN_SEC_TICKS  = 8'(PERIOD_10S_MS / TICK_MS);
	localparam logic [7:0]  LOSS_TICKS     = 8'(SPEED_LOSS_MS / TICK_MS);
	localparam logic [11:0] TENTH_H_TICKS  = 12'(TENTH_HOUR_MS / TICK_MS);

	// ========================================
	// Limits, all distances in tenths of a unit
	localparam logic [26:0] ODO_MAX        = 27'h5F5E0FF;
	localparam logic [19:0] TRIP_MAX       = 20'hF423F;
	localparam logic [16:0] HOURS_MAX      = 17'h1869F;
	localparam logic [26:0] MATCH_TOL      = 27'h0000002;
	localparam logic [15:0] SPEED_THRESH   = 16'h0032;
	localparam logic [7:0]  COMMIT_FAST    = 8'hC8;
	localparam logic [19:0] SPEED_PER_TEN  = 20'h08CA0;
	localparam logic [9:0]  LOW_FUEL_PCT   = 10'h07D;
	localparam logic [4:0]  SVC_IDX_MAX    = 5'h11;
	localparam logic [4:0]  SVC_IDX_RST    = 5'h0C;
	localparam logic [4:0]  SVC_BASE       = 5'h03;
	localparam logic [26:0] SVC_STEP       = 27'h0002710;

	// ========================================
	// Register map (byte addresses)
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_CMD     = 8'h04;
	localparam logic [7:0] REG_MAIN    = 8'h08;
	localparam logic [7:0] REG_CONTENT = 8'h0C;
	localparam logic [7:0] REG_ODO     = 8'h10;
	localparam logic [7:0] REG_TRIP1_D = 8'h14;
	localparam logic [7:0] REG_TRIP2_D = 8'h18;
	localparam logic [7:0] REG_TRIP1_T = 8'h1C;
	localparam logic [7:0] REG_TRIP2_T = 8'h20;
	localparam logic [7:0] REG_HOURS   = 8'h24;
	localparam logic [7:0] REG_SVC     = 8'h28;
	localparam logic [7:0] REG_STATUS  = 8'h2C;

	// Command bits
	localparam int CMD_TRIP0 = 0;
	localparam int CMD_SVC   = 2;
	localparam int CMD_NEXT  = 3;

	// ========================================
	// Enumerations
	typedef enum logic [1:0] {
		METH_DIRECT = 2'b00,
		METH_SPEED  = 2'b01,
		METH_MATCH  = 2'b10
	} dha_method_type;

	localparam logic [4:0] ITEM_ODO     = 5'h0F;
	localparam logic [4:0] ITEM_HOURS   = 5'h09;
	localparam logic [4:0] ITEM_LAST    = 5'h10;

	// ========================================
	// Carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dha_apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dha_apb_rsp_type;

	typedef struct packed {
		logic [31:0] total_dist;
		logic        total_valid;
		logic [15:0] speed;
		logic        speed_valid;
		logic        dist_tick;
		logic [31:0] hours;
		logic        hours_valid;
	} dha_bus_rx_type;

endpackage

`default_nettype wire

/* rtl/dha_top.sv */
// Distance, hours and screen selection logic of the instrument cluster
// Operation
// - User picks main screen, restored at ignition-on
// - Stepping always, content edits need park brake
// - Reconnect selects primary screen, keeps bottom item
// - Odometer saturates at 9999999.9
// - Odometer starts at zero, never resettable
// - Direct method shows bus total distance
// - Speed method loads stored value, integrates per 100ms
// - Last speed used eight seconds, then stop
// - Speed method display refresh every half second
// - Above 5 MPH commit every 20 miles
// - Below 5 MPH commit each tenth, ignition-off
// - Match mode compares within 0.2, counts ticks
// - Match mode commits each tenth and ignition-off
// - Two resettable trips, saturate at 99999.9
// - Trip distance is total minus reset snapshot
// - Trip values persist through ignition and battery
// - Fuel percent every 10s, low flag below 12.5
// - Request engine hours at ignition-on, every 10s
// - Keep last hours, zero if never received
// - Engine hours freeze at 99999
// - Eighteen service intervals 3000 to 20000, off
// - Service default 15000 enabled, remaining or overdue
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none

module dha_top
	import dha_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
	// Clock and reset
	input  wire logic             I_CLK,
	input  wire logic             I_RST_N,
	// Register bus
	input  wire dha_apb_req_type  I_APB,
	output dha_apb_rsp_type       O_APB,
	// Pins
	input  wire logic             I_IGNITION,
	input  wire logic             I_PARK_BRAKE,
	input  wire logic             I_BATT_RECONNECT,
	// Vehicle data bus receive and request
	input  wire dha_bus_rx_type   I_BUS,
	output logic                  O_HOURS_REQ,
	// Sensor data
	input  wire logic [9:0]       I_FUEL_PCT,
	// Display and storage
	output logic [26:0]           O_ODO_SHOWN,
	output logic [16:0]           O_HOURS_SHOWN,
	output logic [9:0]            O_FUEL_PCT,
	output logic                  O_LOW_FUEL,
	output logic [1:0]            O_SCREEN,
	output logic [4:0]            O_TOP_ITEM,
	output logic [4:0]            O_BOT_ITEM,
	output logic                  O_ODO_COMMIT,
	output logic [26:0]           O_ODO_STORED
);

	// ========================================
	// Pin synchronisers
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic       ign_prev_q;
	logic       batt_prev_q;
	wire        ign     = pin_s2_q[0];
	wire        park    = pin_s2_q[1];
	wire        ign_on  = ign & ~ign_prev_q;
	wire        ign_off = ~ign & ign_prev_q;
	wire        reconn  = pin_s2_q[2] & ~batt_prev_q;

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			pin_s1_q    <= 3'h0;
			pin_s2_q    <= 3'h0;
			ign_prev_q  <= 1'b0;
			batt_prev_q <= 1'b0;
		end else begin
			pin_s1_q    <= {I_BATT_RECONNECT, I_PARK_BRAKE, I_IGNITION};
			pin_s2_q    <= pin_s1_q;
			ign_prev_q  <= ign;
			batt_prev_q <= pin_s2_q[2];
		end
	end

	// ========================================
	// 100 ms tick and derived periods
	logic [31:0] tick_cnt_q;
	logic [7:0]  half_cnt_q;
	logic [7:0]  ten_cnt_q;
	logic [11:0] hour_cnt_q;
	wire         tick     = (tick_cnt_q == 32'(TICK_CYC - 1));
	wire         half_sec = tick & (half_cnt_q == HALF_SEC_TICKS - 8'h01);
	wire         ten_sec  = tick & (ten_cnt_q == TEN_SEC_TICKS - 8'h01);
	wire         tenth_hr = tick & ign & (hour_cnt_q == TENTH_H_TICKS - 12'h001);

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			tick_cnt_q <= 32'h0;
			half_cnt_q <= 8'h00;
			ten_cnt_q  <= 8'h00;
			hour_cnt_q <= 12'h000;
		end else begin
			tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
			// Ten-second period restarts at ignition-on so requests stay spaced
			if (ign_on)
				ten_cnt_q <= 8'h00;
			else if (tick)
				ten_cnt_q <= ten_sec ? 8'h00 : ten_cnt_q + 8'h01;
			if (tick) begin
				half_cnt_q <= half_sec ? 8'h00 : half_cnt_q + 8'h01;
				if (ign)
					hour_cnt_q <= tenth_hr ? 12'h000 : hour_cnt_q + 12'h001;
			end
		end
	end

	// ========================================
	// Register bus slave
	logic        ready_q;
	logic        err_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata;
	logic        map_hit;
	logic [1:0]  method_q;
	logic        metric_q;
	logic        svc_en_q;
	logic [4:0]  svc_idx_q;
	wire         acc    = I_APB.psel & I_APB.penable;
	wire         wr_en  = acc & ready_q & I_APB.pwrite & map_hit;
	wire         wr_ctl = wr_en & (I_APB.paddr == REG_CTRL);
	wire         wr_cmd = wr_en & (I_APB.paddr == REG_CMD);
	wire         wr_mn  = wr_en & (I_APB.paddr == REG_MAIN);
	wire         wr_cnt = wr_en & (I_APB.paddr == REG_CONTENT) & park;
	wire [31:0]  wd     = I_APB.pwdata;

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			ready_q <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ready_q <= acc & ~ready_q;
			err_q   <= acc & ~ready_q & ~map_hit;
			if (acc & ~ready_q)
				rdata_q <= rdata;
		end
	end

	assign O_APB = '{prdata: rdata_q, pready: ready_q, pslverr: err_q};

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			method_q  <= METH_DIRECT;
			metric_q  <= 1'b0;
			svc_en_q  <= 1'b1;
			svc_idx_q <= SVC_IDX_RST;
		end else if (wr_ctl) begin
			method_q <= wd[1:0];
			metric_q <= wd[2];
			svc_en_q <= wd[3];
			if (wd[8:4] <= SVC_IDX_MAX)
				svc_idx_q <= wd[8:4];
		end
	end

	// ========================================
	// Screen selection
	logic [1:0] main_q;
	logic [1:0] scr_q;
	logic [9:0] content_q [4];
	wire        screen_next = wr_cmd & wd[CMD_NEXT];
	wire        content_ok  = wd[7:3] <= ITEM_LAST;

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			main_q <= 2'h0;
			scr_q  <= 2'h0;
			for (int s = 0; s < 4; s++)
				content_q[s] <= {ITEM_ODO, ITEM_HOURS};
		end else begin
			if (reconn) begin
				main_q <= 2'h0;
				scr_q  <= 2'h0;
			end else if (ign_on) begin
				scr_q <= main_q;
			end else begin
				if (wr_mn)
					main_q <= wd[1:0];
				if (screen_next)
					scr_q <= scr_q + 2'h1;
			end
			if (wr_cnt & content_ok) begin
				if (wd[2])
					content_q[wd[1:0]][4:0] <= wd[7:3];
				else if (wd[1:0] != 2'h0)
					content_q[wd[1:0]][9:5] <= wd[7:3];
			end
		end
	end

	assign O_SCREEN   = scr_q;
	assign O_TOP_ITEM = (scr_q == 2'h0) ? ITEM_ODO : content_q[scr_q][9:5];
	assign O_BOT_ITEM = content_q[scr_q][4:0];

	// ========================================
	// Odometer
	logic [26:0] odo_q;
	logic [26:0] nv_odo_q;
	logic [26:0] shown_q;
	logic [19:0] spd_acc_q;
	logic [15:0] speed_q;
	logic [7:0]  age_q;
	logic [7:0]  since_q;
	logic        match_q;
	logic        commit_q;
	logic [26:0] total_q;
	wire [26:0]  bus_total = (I_BUS.total_dist > 32'(ODO_MAX)) ? ODO_MAX : I_BUS.total_dist[26:0];
	// Match test uses the last broadcast total, never the idle bus value
	wire [26:0]  diff      = (nv_odo_q > total_q) ? nv_odo_q - total_q : total_q - nv_odo_q;
	wire         speed_ok  = age_q < LOSS_TICKS;
	wire [19:0]  acc_sum   = spd_acc_q + 20'(speed_q);
	wire         spd_inc   = ign & tick & speed_ok & (acc_sum >= SPEED_PER_TEN);
	wire         mtc_inc   = ign & match_q & I_BUS.dist_tick;
	wire         inc       = (method_q == METH_SPEED) ? spd_inc :
	                         (method_q == METH_MATCH) ? mtc_inc : 1'b0;
	wire         odo_inc   = inc & (odo_q != ODO_MAX);
	wire         fast      = speed_q > SPEED_THRESH;
	wire         commit_inc = (method_q == METH_MATCH) | ~fast | (since_q + 8'h01 >= COMMIT_FAST);
	wire         commit    = ign_off | (odo_inc & commit_inc);
	wire [26:0]  odo_d     = odo_inc ? odo_q + 27'h1 : odo_q;

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			odo_q     <= 27'h0;
			nv_odo_q  <= 27'h0;
			shown_q   <= 27'h0;
			spd_acc_q <= 20'h0;
			speed_q   <= 16'h0;
			age_q     <= 8'h00;
			since_q   <= 8'h00;
			match_q   <= 1'b0;
			commit_q  <= 1'b0;
			total_q   <= 27'h0;
		end else begin
			commit_q <= commit;
			if (I_BUS.total_valid)
				total_q <= bus_total;
			if (I_BUS.speed_valid) begin
				speed_q <= I_BUS.speed;
				age_q   <= 8'h00;
			end else if (tick & speed_ok) begin
				age_q <= age_q + 8'h01;
			end
			if (ign & tick & speed_ok & (method_q == METH_SPEED))
				spd_acc_q <= (acc_sum >= SPEED_PER_TEN) ? acc_sum - SPEED_PER_TEN : acc_sum;
			if (ign_on) begin
				odo_q   <= nv_odo_q;
				match_q <= diff <= MATCH_TOL;
			end else if (method_q == METH_DIRECT) begin
				if (I_BUS.total_valid)
					odo_q <= bus_total;
			end else begin
				odo_q <= odo_d;
			end
			if (commit) begin
				nv_odo_q <= (method_q == METH_DIRECT) ? odo_q : odo_d;
				since_q  <= 8'h00;
			end else if (odo_inc) begin
				since_q <= since_q + 8'h01;
			end
			if (method_q != METH_SPEED | half_sec)
				shown_q <= odo_q;
		end
	end

	assign O_ODO_SHOWN  = shown_q;
	assign O_ODO_COMMIT = commit_q;
	assign O_ODO_STORED = nv_odo_q;

	// ========================================
	// Trip counters
	logic [26:0] trip_snap_q [2];
	logic [19:0] trip_time_q [2];
	logic [19:0] trip_dist   [2];

	generate
		for (genvar t = 0; t < 2; t++) begin : g_trip
			wire        rst_trip = wr_cmd & wd[CMD_TRIP0 + t];
			wire [26:0] span     = odo_q - trip_snap_q[t];
			assign trip_dist[t] = (span > 27'(TRIP_MAX)) ? TRIP_MAX : span[19:0];
			always_ff @(posedge I_CLK) begin
				if (!I_RST_N) begin
					trip_snap_q[t] <= 27'h0;
					trip_time_q[t] <= 20'h0;
				end else if (rst_trip) begin
					trip_snap_q[t] <= odo_q;
					trip_time_q[t] <= 20'h0;
				end else if (tenth_hr & (trip_time_q[t] != TRIP_MAX)) begin
					trip_time_q[t] <= trip_time_q[t] + 20'h1;
				end
			end
		end
	endgenerate

	// ========================================
	// Engine hours and fuel
	logic [16:0] hours_q;
	logic        hreq_q;
	logic [9:0]  fuel_q;
	wire  [16:0] hours_in = (I_BUS.hours > 32'(HOURS_MAX)) ? HOURS_MAX : I_BUS.hours[16:0];

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			hours_q <= 17'h0;
			hreq_q  <= 1'b0;
			fuel_q  <= 10'h3E8;
		end else begin
			hreq_q <= ign_on | (ign & ten_sec);
			if (ign & I_BUS.hours_valid & (hours_q != HOURS_MAX))
				hours_q <= hours_in;
			if (ign & ten_sec)
				fuel_q <= I_FUEL_PCT;
		end
	end

	assign O_HOURS_REQ   = hreq_q;
	assign O_HOURS_SHOWN = hours_q;
	assign O_FUEL_PCT    = fuel_q;
	assign O_LOW_FUEL    = fuel_q < LOW_FUEL_PCT;

	// ========================================
	// Service reminder
	logic [26:0] svc_snap_q;
	wire  [26:0] svc_int  = 27'(svc_idx_q + SVC_BASE) * SVC_STEP;
	wire  [26:0] svc_used = odo_q - svc_snap_q;
	wire         overdue  = svc_en_q & (svc_used > svc_int);
	wire  [26:0] svc_left = overdue ? svc_used - svc_int : svc_int - svc_used;

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N)
			svc_snap_q <= 27'h0;
		else if (wr_cmd & wd[CMD_SVC])
			svc_snap_q <= odo_q;
	end

	// ========================================
	// Read decode
	always_comb begin
		map_hit = 1'b1;
		case (I_APB.paddr)
			REG_CTRL:    rdata = {23'h0, svc_idx_q, svc_en_q, metric_q, method_q};
			REG_CMD:     rdata = 32'h0;
			REG_MAIN:    rdata = {30'h0, main_q};
			REG_CONTENT: rdata = {22'h0, content_q[scr_q]};
			REG_ODO:     rdata = {5'h0, shown_q};
			REG_TRIP1_D: rdata = {12'h0, trip_dist[0]};
			REG_TRIP2_D: rdata = {12'h0, trip_dist[1]};
			REG_TRIP1_T: rdata = {12'h0, trip_time_q[0]};
			REG_TRIP2_T: rdata = {12'h0, trip_time_q[1]};
			REG_HOURS:   rdata = {15'h0, hours_q};
			REG_SVC:     rdata = {5'h0, svc_en_q ? svc_left : 27'h0};
			REG_STATUS:  rdata = {14'h0, fuel_q, scr_q, ~speed_ok, match_q, overdue, O_LOW_FUEL, park, ign};
			default: begin
				rdata   = 32'h0;
				map_hit = 1'b0;
			end
		endcase
	end

endmodule

`default_nettype wire

/* sim/dha_engine_model.sv */
// Engine controller model on the vehicle data bus
`timescale 1ns/10ps
`default_nettype none
module dha_engine_model
	import dha_pkg::*;
(
	// Clock and request
	input  wire logic        i_clk,
	input  wire logic        i_hours_req,
	// Scenario controls
	input  wire logic [31:0] i_total,
	input  wire logic [15:0] i_speed,
	input  wire logic        i_speed_on,
	input  wire logic [31:0] i_hours,
	input  wire logic        i_reply_on,
	input  wire logic        i_slow,
	input  wire logic        i_tick,
	// Bus output
	output dha_bus_rx_type   o_bus
);
	int cnt = 0;
	int wait_q = -1;
	always @(posedge i_clk) begin
		cnt <= cnt + 1;
		o_bus.total_valid <= (cnt % 10 == 0);
		o_bus.total_dist <= (cnt % 10 == 0) ? i_total : ~i_total;
		o_bus.speed_valid <= i_speed_on && (cnt % 15 == 0);
		o_bus.speed <= (i_speed_on && cnt % 15 == 0) ? i_speed : 16'(cnt);
		o_bus.dist_tick <= i_tick;
		o_bus.hours_valid <= (wait_q == 0);
		o_bus.hours <= (wait_q == 0) ? i_hours : ~i_hours;
		if (i_hours_req && i_reply_on) wait_q <= i_slow ? 40 : 2;
		else if (wait_q >= 0) wait_q <= wait_q - 1;
	end
endmodule
`default_nettype wire

/* sim/dha_top_chk.sv */
// Concurrent checks on the top ports of the accumulator
`timescale 1ns/10ps
`default_nettype none
module dha_top_chk
	import dha_pkg::*;
(
	// Clock, reset, bus and pins
	input wire logic            I_CLK,
	input wire logic            I_RST_N,
	input wire dha_apb_req_type I_APB,
	input wire dha_apb_rsp_type O_APB,
	input wire logic            I_IGNITION,
	input wire logic            I_BATT_RECONNECT,
	// Watched outputs
	input wire logic            O_HOURS_REQ,
	input wire logic [26:0]     O_ODO_SHOWN,
	input wire logic [16:0]     O_HOURS_SHOWN,
	input wire logic [9:0]      O_FUEL_PCT,
	input wire logic            O_LOW_FUEL,
	input wire logic [1:0]      O_SCREEN,
	input wire logic [4:0]      O_TOP_ITEM,
	input wire logic            O_ODO_COMMIT,
	input wire logic [26:0]     O_ODO_STORED
);
	// ====
	// Checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	chk_odo_limit: assert property (O_ODO_SHOWN <= ODO_MAX && O_ODO_STORED <= ODO_MAX)
		else $error("odometer past limit");
	chk_store_commit: assert property ($changed(O_ODO_STORED) |-> O_ODO_COMMIT)
		else $error("store without commit");
	chk_hours_limit: assert property (O_HOURS_SHOWN <= HOURS_MAX)
		else $error("hours past limit");
	chk_low_fuel: assert property (O_LOW_FUEL == (O_FUEL_PCT < LOW_FUEL_PCT))
		else $error("low fuel flag wrong");
	chk_req_on: assert property ($rose(I_IGNITION) |-> ##[2:5] O_HOURS_REQ)
		else $error("no hours request");
	chk_req_gap: assert property (O_HOURS_REQ |=> !O_HOURS_REQ [*8])
		else $error("hours request too soon");
	chk_top_odo: assert property (O_SCREEN == 2'h0 |-> O_TOP_ITEM == ITEM_ODO)
		else $error("primary top not odometer");
	chk_off_commit: assert property ($fell(I_IGNITION) |-> ##[2:5] O_ODO_COMMIT)
		else $error("no commit at ignition off");
	chk_reconnect: assert property ($rose(I_BATT_RECONNECT) |-> ##[2:6] O_SCREEN == 2'h0)
		else $error("reconnect screen wrong");
	chk_apb_wait: assert property (I_APB.psel && !I_APB.penable |=> !O_APB.pready ##1 O_APB.pready)
		else $error("bus wait state wrong");
endmodule
bind dha_top dha_top_chk u_chk (
	.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_APB(I_APB), .O_APB(O_APB), .I_IGNITION(I_IGNITION),
	.I_BATT_RECONNECT(I_BATT_RECONNECT), .O_HOURS_REQ(O_HOURS_REQ), .O_ODO_SHOWN(O_ODO_SHOWN),
	.O_HOURS_SHOWN(O_HOURS_SHOWN), .O_FUEL_PCT(O_FUEL_PCT), .O_LOW_FUEL(O_LOW_FUEL), .O_SCREEN(O_SCREEN),
	.O_TOP_ITEM(O_TOP_ITEM), .O_ODO_COMMIT(O_ODO_COMMIT), .O_ODO_STORED(O_ODO_STORED)
);
`default_nettype wire

/* sim/dha_top_test.sv */
// Self-checking testbench of the accumulator
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin errors++; $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module dha_top_test
	import dha_pkg::*;
;
	// ====
	// Signals
	logic            clk = 0, rst_n = 0, ign = 0, park = 0, recon = 0, hreq, commit, low_fuel, last_err;
	logic            speed_on = 0, reply_on = 1, slow = 0, tick = 0;
	dha_apb_req_type req = '0;
	dha_apb_rsp_type rsp;
	dha_bus_rx_type  bus;
	logic [31:0]     total = '0, hours = '0, rd;
	logic [15:0]     speed = '0;
	logic [9:0]      fuel = 10'h3E8, fuel_o;
	logic [26:0]     odo, stored, base, t_odo;
	logic [16:0]     hrs;
	logic [1:0]      scr;
	logic [4:0]      top, bot, t0;
	int              errors = 0, num_checks = 0, cycles = 0, ncommit = 0, n;
	dha_top #(.TICK_CYC(20)) dut (
		.I_CLK(clk), .I_RST_N(rst_n), .I_APB(req), .O_APB(rsp), .I_IGNITION(ign), .I_PARK_BRAKE(park),
		.I_BATT_RECONNECT(recon), .I_BUS(bus), .O_HOURS_REQ(hreq), .I_FUEL_PCT(fuel), .O_ODO_SHOWN(odo),
		.O_HOURS_SHOWN(hrs), .O_FUEL_PCT(fuel_o), .O_LOW_FUEL(low_fuel), .O_SCREEN(scr), .O_TOP_ITEM(top),
		.O_BOT_ITEM(bot), .O_ODO_COMMIT(commit), .O_ODO_STORED(stored)
	);
	dha_engine_model ecu (
		.i_clk(clk), .i_hours_req(hreq), .i_total(total), .i_speed(speed), .i_speed_on(speed_on),
		.i_hours(hours), .i_reply_on(reply_on), .i_slow(slow), .i_tick(tick), .o_bus(bus)
	);
	initial begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (commit === 1'b1) ncommit <= ncommit + 1;
		if (cycles == 40000) begin
			errors++;
			tally_and_finish();
		end
	end
	// ====
	// Helpers
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		last_err = rsp.pslverr;
		req <= '0;
	endtask
	task automatic ignit(input logic v);
		ign <= v;
		cyc(10);
	endtask
	task automatic pulse_tick();
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		cyc(10);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ====
	// Scenarios
	task automatic t_service();
		apb(1'b0, REG_ODO, '0);
		`CHK("odo reset", 32'h0, rd)
		apb(1'b0, REG_HOURS, '0);
		`CHK("hours reset", 32'h0, rd)
		apb(1'b0, REG_SVC, '0);
		`CHK("svc reset", 32'h000249F0, rd)
		apb(1'b0, 8'h30, '0);
		`CHK("unmapped", 1'b1, last_err)
		for (int i = 0; i < 19; i++) begin
			apb(1'b1, REG_CTRL, 32'(8 | (i << 4)));
			apb(1'b0, REG_SVC, '0);
			`CHK("svc interval", 32'((i > 17 ? 20 : 3 + i) * 10000), rd)
		end
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b0, REG_SVC, '0);
		`CHK("svc off", 32'h0, rd)
	endtask
	task automatic t_direct();
		apb(1'b1, REG_CTRL, 32'h000000C8);
		total <= 32'h00001234;
		hours <= 32'h000004D2;
		fuel <= 10'h064;
		ignit(1'b1);
		cyc(20);
		`CHK("direct odo", 27'h0001234, odo)
		`CHK("hours", 17'h004D2, hrs)
		cyc(2020);
		`CHK("fuel", 10'h064, fuel_o)
		`CHK("low fuel", 1'b1, low_fuel)
		reply_on <= 1'b0;
		hours <= 32'h7;
		ignit(1'b0);
		`CHK("direct stored", 27'h0001234, stored)
		ignit(1'b1);
		cyc(20);
		`CHK("hours kept", 17'h004D2, hrs)
		reply_on <= 1'b1;
		slow <= 1'b1;
		hours <= 32'h000186A4;
		cyc(2060);
		`CHK("hours max", HOURS_MAX, hrs)
		fuel <= 10'h1F4;
		ignit(1'b0);
	endtask
	task automatic t_speed();
		apb(1'b1, REG_CTRL, 32'h000000C9);
		base = stored;
		speed <= 16'h0E10;
		speed_on <= 1'b1;
		ignit(1'b1);
		cyc(2000);
		speed_on <= 1'b0;
		cyc(4000);
		`CHK("fuel level", 10'h1F4, fuel_o)
		`CHK("fuel not low", 1'b0, low_fuel)
		t_odo = odo;
		`CHK("speed odo", 1'b1, t_odo >= base + 27'h10 && t_odo <= base + 27'h14)
		cyc(1000);
		`CHK("speed frozen", t_odo, odo)
		ignit(1'b0);
		`CHK("speed stored", t_odo, stored)
	endtask
	task automatic t_match();
		apb(1'b1, REG_CTRL, 32'h000000CA);
		base = stored;
		total <= 32'(base) + 32'h2;
		cyc(12);
		ignit(1'b1);
		apb(1'b0, REG_STATUS, '0);
		`CHK("match ok", 1'b1, rd[4])
		apb(1'b1, REG_CMD, 32'h1);
		n = ncommit;
		repeat (3) pulse_tick();
		`CHK("match odo", base + 27'h3, odo)
		`CHK("tenth commits", 3, ncommit - n)
		apb(1'b0, REG_TRIP1_D, '0);
		`CHK("trip1", 32'h3, rd)
		apb(1'b0, REG_TRIP2_D, '0);
		`CHK("trip2", 32'(base) + 32'h3, rd)
		apb(1'b1, REG_CMD, 32'h6);
		apb(1'b0, REG_TRIP2_D, '0);
		`CHK("trip2 cleared", 32'h0, rd)
		apb(1'b0, REG_SVC, '0);
		`CHK("svc restart", 32'h000249F0, rd)
		total <= 32'(base) + 32'h9;
		ignit(1'b0);
		`CHK("match stored", base + 27'h3, stored)
		ignit(1'b1);
		pulse_tick();
		`CHK("mismatch held", base + 27'h3, odo)
	endtask
	task automatic t_screen();
		apb(1'b1, REG_MAIN, 32'h2);
		ignit(1'b0);
		ignit(1'b1);
		`CHK("main restored", 2'h2, scr)
		apb(1'b1, REG_CMD, 32'h8);
		cyc(2);
		`CHK("step", 2'h3, scr)
		t0 = top;
		apb(1'b1, REG_CONTENT, 32'h6B);
		cyc(2);
		`CHK("edit refused", t0, top)
		park <= 1'b1;
		apb(1'b1, REG_CONTENT, 32'h6B);
		cyc(2);
		`CHK("edit taken", 5'h0D, top)
		apb(1'b1, REG_CMD, 32'h8);
		apb(1'b1, REG_CONTENT, 32'h28);
		apb(1'b1, REG_CONTENT, 32'h14);
		cyc(2);
		`CHK("top fixed", ITEM_ODO, top)
		apb(1'b1, REG_CMD, 32'h8);
		recon <= 1'b1;
		cyc(6);
		recon <= 1'b0;
		cyc(4);
		`CHK("reconnect screen", 2'h0, scr)
		`CHK("reconnect bottom", 5'h02, bot)
		apb(1'b0, REG_TRIP1_D, '0);
		`CHK("trip kept", 32'h3, rd)
	endtask
	initial begin
		cyc(4);
		rst_n <= 1'b1;
		t_service();
		t_direct();
		t_speed();
		t_match();
		t_screen();
		tally_and_finish();
	end
endmodule
`default_nettype wire
